// ==== design/sacfg_pkg.sv ====
// package: constants and carriers for the sector architecture and ecc status bank
package sacfg_pkg;

    // ------------------------------------------------------------
    // register layout
    // ------------------------------------------------------------
    localparam int          REG_W           = 8;
    localparam int          SECT_OPT_W      = 4;
    localparam int          ECC_DOUBLE_BIT  = 4;
    localparam int          ECC_SINGLE_BIT  = 3;
    localparam logic [3:0]  OPT_LAST_DEFINED = 4'h7;
    localparam logic [3:0]  OPT_MODEL_A     = 4'h5;
    localparam logic [3:0]  OPT_MODEL_B     = 4'h0;
    localparam logic [3:0]  ARCH_RSVD_VALUE = 4'h0;
    localparam logic [7:0]  ECC_STATUS_RST  = 8'h00;
    localparam logic        LOCK_RST        = 1'b0;
    localparam logic [7:0]  RD_DATA_RST     = 8'h00;
    localparam logic [31:0] UNIT_ADDR_RST   = 32'h0000_0000;

    // ------------------------------------------------------------
    // ecc data unit
    // ------------------------------------------------------------
    localparam int          UNIT_BYTES      = 16;
    localparam int          UNIT_BITS       = 128;
    localparam int          UNIT_ADDR_LSB   = $clog2(UNIT_BYTES);
    localparam int          ARRAY_ADDR_W    = 32;

    // ------------------------------------------------------------
    // serial read-out
    // ------------------------------------------------------------
    localparam int          SYNC_STAGES     = 2;
    localparam logic [2:0]  SHIFT_LAST      = 3'h7;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        SACFG_SEL_ARCH,
        SACFG_SEL_ECC
    } sacfg_sel_e;

    typedef struct packed {
        logic                    valid;
        sacfg_sel_e              sel;
        logic [REG_W-1:0]        data;
    } sacfg_wr_s;

    typedef struct packed {
        logic                    valid;
        logic [ARRAY_ADDR_W-1:0] addr;
        logic                    single_corr;
        logic                    double_det;
    } sacfg_rd_s;

endpackage : sacfg_pkg

// ==== design/sacfg_serial_out.sv ====
// serial read-out of one register byte, timed by the sampled link clock
`timescale 1ns/1ps
`default_nettype none

module sacfg_serial_out (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // link pins
    input  wire logic       sck,
    input  wire logic       cs_n,
    output logic            so,
    output logic            so_oe_n,
    // byte to send
    input  wire logic [7:0] load_byte
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sck_sync;
    logic [1:0] cs_sync;
    logic       sck_prev;
    logic       cs_prev;
    logic [7:0] shreg;
    logic [2:0] bit_cnt;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sck_sync <= 2'h0;
            cs_sync  <= 2'h3;
            sck_prev <= 1'b0;
            cs_prev  <= 1'b1;
        end else begin
            sck_sync <= {sck_sync[0], sck};
            cs_sync  <= {cs_sync[0], cs_n};
            sck_prev <= sck_sync[1];
            cs_prev  <= cs_sync[1];
        end
    end

    wire frame_start = cs_prev & ~cs_sync[1];
    wire frame_on    = ~cs_sync[1];
    wire sck_fall    = sck_prev & ~sck_sync[1];

    // ------------------------------------------------------------
    // shifter: msb first, next bit on each falling edge
    // ------------------------------------------------------------
    wire [7:0] next_shreg = {shreg[6:0], 1'b0};

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            shreg   <= 8'h00;
            bit_cnt <= 3'h0;
            so      <= 1'b0;
            so_oe_n <= 1'b1;
        end else if (frame_start) begin
            shreg   <= load_byte;
            bit_cnt <= 3'h0;
            so      <= load_byte[7];
            so_oe_n <= 1'b0;
        end else if (!frame_on) begin
            so_oe_n <= 1'b1;
        end else if (sck_fall) begin
            // byte repeats after the eighth bit, as a register read does
            shreg   <= (bit_cnt == sacfg_pkg::SHIFT_LAST) ? load_byte : next_shreg;
            so      <= (bit_cnt == sacfg_pkg::SHIFT_LAST) ? load_byte[7] : shreg[6];
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

endmodule : sacfg_serial_out

`default_nettype wire

// ==== design/sacfg_bank.sv ====
// sector architecture configuration and ecc error status register bank
// Functional notes
// - new sector option becomes active only after chip-select, hardware or power-on reset (srst here reloads the factory option instead)
// - only one change from factory value allowed, then the field locks
// - writing the factory value again locks the default architecture
// - four-bit option code; options 0 to 7 defined, 8 to 15 reserved
// - permanent architecture lock in config register one refuses option writes
// - factory default option depends on model: option 5 or option 0
// - ecc works on sixteen-byte data units, status per unit
// - ecc status reflects the unit holding the last read byte (here the flags stay set across reads until cleared)
// - bit 4 set on a double-bit error in a read unit
// - bit 3 set on a corrected single-bit error in a read unit
// - both ecc flags evaluated every array read and sticky
// - ecc flags hold until the clear ecc status command zeroes them
// - ecc status is volatile read-only, resets to zero, reserved bits zero
`timescale 1ns/1ps
`default_nettype none

module sacfg_bank #(
    parameter logic [3:0] FACTORY_OPTION = sacfg_pkg::OPT_MODEL_A
) (
    // clock and reset (srst also stands for power-on reset)
    input  wire logic                                  clk_sys,
    input  wire logic                                  srst,
    // chip-select signalling or hardware reset, one-cycle pulse
    input  wire logic                                  arch_reset_req,
    // lock bit from config register one
    input  wire logic                                  permanent_arch_lock,
    // generic register write and read select
    input  wire sacfg_pkg::sacfg_wr_s                  reg_wr,
    input  wire sacfg_pkg::sacfg_sel_e                 reg_rd_sel,
    output logic [sacfg_pkg::REG_W-1:0]                reg_rd_data,
    output logic                                       wr_accept,
    output logic                                       wr_reject,
    // array read results and ecc clear
    input  wire sacfg_pkg::sacfg_rd_s                  array_rd,
    input  wire logic                                  clear_ecc_status_cmd,
    // architecture and ecc status outputs
    output logic [sacfg_pkg::SECT_OPT_W-1:0]           active_option,
    output logic                                       option_locked,
    output logic [sacfg_pkg::ARRAY_ADDR_W-1:0]         last_unit_addr,
    output logic                                       double_bit_error_flag,
    output logic                                       single_bit_corrected_flag,
    // serial read-out pins
    input  wire logic                                  sck,
    input  wire logic                                  cs_n,
    output logic                                       so,
    output logic                                       so_oe_n
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // stored value models the non-volatile cell; a power-on reset
    // restores the factory image since no real cell is behind it
    logic [3:0] sector_option_field;
    logic       locked;

    // ------------------------------------------------------------
    // architecture write decode
    // ------------------------------------------------------------
    wire        arch_wr      = reg_wr.valid && (reg_wr.sel == sacfg_pkg::SACFG_SEL_ARCH);
    wire        ecc_wr       = reg_wr.valid && (reg_wr.sel == sacfg_pkg::SACFG_SEL_ECC);
    wire [3:0]  wr_option    = reg_wr.data[sacfg_pkg::SECT_OPT_W-1:0];

    // ------------------------------------------------------------
    // refusal reasons
    // ------------------------------------------------------------
    wire        opt_reserved = wr_option > sacfg_pkg::OPT_LAST_DEFINED;
    wire        lock_refuse  = permanent_arch_lock | locked;
    wire        arch_refuse  = lock_refuse | opt_reserved;
    wire        arch_take    = arch_wr & ~arch_refuse;
    // the status register has no writable bit, so every write is refused
    wire        ecc_refuse   = ecc_wr;
    wire        next_accept  = arch_take;
    wire        next_reject  = (arch_wr & arch_refuse) | ecc_refuse;

    // ------------------------------------------------------------
    // stored option and its one-time lock
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sector_option_field <= FACTORY_OPTION;
        end else if (arch_take) begin
            // same value as factory also locks; upper bits are dropped
            sector_option_field <= wr_option;
        end
    end

    // a refused write leaves the lock as it was
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            locked <= sacfg_pkg::LOCK_RST;
        end else if (arch_take) begin
            locked <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // write answers, one-cycle pulses
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_accept <= 1'b0;
        end else begin
            wr_accept <= next_accept;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_reject <= 1'b0;
        end else begin
            wr_reject <= next_reject;
        end
    end

    // ------------------------------------------------------------
    // active architecture: follows the stored value only on a reset
    // ------------------------------------------------------------
    // a write landing in the same cycle as the reset request is only
    // activated by the next reset, since the old stored value is copied
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            active_option <= FACTORY_OPTION;
        end else if (arch_reset_req) begin
            active_option <= sector_option_field;
        end
    end

    // ------------------------------------------------------------
    // lock status
    // ------------------------------------------------------------
    // includes the write taken this cycle, so it rises with the accept pulse
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            option_locked <= sacfg_pkg::LOCK_RST;
        end else begin
            option_locked <= locked | arch_take;
        end
    end

    // ------------------------------------------------------------
    // ecc status: sticky, set wins over clear
    // ------------------------------------------------------------
    wire        set_double    = array_rd.valid & array_rd.double_det;
    wire        set_single    = array_rd.valid & array_rd.single_corr;
    // an error reported in the cycle of the clear must not be lost
    wire        next_double   = set_double | (double_bit_error_flag & ~clear_ecc_status_cmd);
    wire        next_single   = set_single | (single_bit_corrected_flag & ~clear_ecc_status_cmd);

    // the single-bit flag is kept even under a double-bit error;
    // making sense of the pair is left to the host
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            double_bit_error_flag     <= sacfg_pkg::ECC_STATUS_RST[sacfg_pkg::ECC_DOUBLE_BIT];
        end else begin
            double_bit_error_flag     <= next_double;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            single_bit_corrected_flag <= sacfg_pkg::ECC_STATUS_RST[sacfg_pkg::ECC_SINGLE_BIT];
        end else begin
            single_bit_corrected_flag <= next_single;
        end
    end

    // ------------------------------------------------------------
    // address of the last data unit read
    // ------------------------------------------------------------
    wire [31:0] next_unit     = {array_rd.addr[sacfg_pkg::ARRAY_ADDR_W-1:sacfg_pkg::UNIT_ADDR_LSB],
                                 {sacfg_pkg::UNIT_ADDR_LSB{1'b0}}};

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            last_unit_addr <= sacfg_pkg::UNIT_ADDR_RST;
        end else if (array_rd.valid) begin
            last_unit_addr <= next_unit;
        end
    end

    // ------------------------------------------------------------
    // read-back; reserved bits read zero
    // ------------------------------------------------------------
    wire [7:0] arch_image = {sacfg_pkg::ARCH_RSVD_VALUE, sector_option_field};
    wire [7:0] ecc_image  = {3'h0, double_bit_error_flag, single_bit_corrected_flag, 3'h0};
    wire       ecc_sel    = (reg_rd_sel == sacfg_pkg::SACFG_SEL_ECC);
    wire [7:0] next_rd    = ecc_sel ? ecc_image : arch_image;

    // registered so the serial side loads a settled byte at frame start
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rd_data <= sacfg_pkg::RD_DATA_RST;
        end else begin
            reg_rd_data <= next_rd;
        end
    end

    // ------------------------------------------------------------
    // serial read-out of the selected register
    // ------------------------------------------------------------
    // the byte sent is whichever register the read select chooses
    sacfg_serial_out u_serial (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .sck       (sck),
        .cs_n      (cs_n),
        .so        (so),
        .so_oe_n   (so_oe_n),
        .load_byte (reg_rd_data)
    );

endmodule : sacfg_bank

`default_nettype wire

// ==== sim/sacfg_bank_props.sv ====
// checker: timing relations on the bank ports
`timescale 1ns/1ps
`default_nettype none
module sacfg_bank_props (
    // clock and reset
    input wire logic                 clk_sys,
    input wire logic                 srst,
    // requests
    input wire logic                 arch_reset_req,
    input wire logic                 permanent_arch_lock,
    input wire sacfg_pkg::sacfg_wr_s reg_wr,
    input wire sacfg_pkg::sacfg_rd_s array_rd,
    input wire logic                 clear_ecc_status_cmd,
    // results
    input wire logic                 wr_accept,
    input wire logic                 wr_reject,
    input wire logic [3:0]           active_option,
    input wire logic                 option_locked,
    input wire logic [31:0]          last_unit_addr,
    input wire logic                 double_bit_error_flag,
    input wire logic                 single_bit_corrected_flag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire arch_wr  = reg_wr.valid && reg_wr.sel == sacfg_pkg::SACFG_SEL_ARCH;
    wire arch_bar = option_locked || permanent_arch_lock || reg_wr.data[3:0] > 4'h7;
    AST_ECC_WR_IGNORED: assert property (
        reg_wr.valid && !arch_wr |=> wr_reject && !wr_accept) else $error("ecc write taken");
    AST_ARCH_REFUSED: assert property (
        arch_wr && arch_bar |=> wr_reject && !wr_accept) else $error("arch write not refused");
    AST_ARCH_TAKEN: assert property (
        arch_wr && !arch_bar |=> wr_accept && option_locked) else $error("arch write lost");
    AST_ACTIVE_HELD: assert property (
        !arch_reset_req |=> $stable(active_option)) else $error("option moved without reset");
    AST_DOUBLE_SET: assert property (
        array_rd.valid && array_rd.double_det |=> double_bit_error_flag) else $error("no double");
    AST_SINGLE_SET: assert property (
        array_rd.valid && array_rd.single_corr |=> single_bit_corrected_flag) else $error("no single");
    AST_STICKY: assert property (
        !clear_ecc_status_cmd |=> double_bit_error_flag >= $past(double_bit_error_flag)
        && single_bit_corrected_flag >= $past(single_bit_corrected_flag)) else $error("flag dropped");
    AST_CLEARED: assert property (
        clear_ecc_status_cmd && !array_rd.valid |=> !double_bit_error_flag
        && !single_bit_corrected_flag) else $error("flags not cleared");
    AST_UNIT_ADDR: assert property (
        array_rd.valid |=> last_unit_addr == {$past(array_rd.addr[31:4]), 4'h0})
        else $error("wrong unit address");
endmodule : sacfg_bank_props
bind sacfg_bank sacfg_bank_props i_props (.clk_sys, .srst, .arch_reset_req,
    .permanent_arch_lock, .reg_wr, .array_rd, .clear_ecc_status_cmd, .wr_accept, .wr_reject,
    .active_option, .option_locked, .last_unit_addr, .double_bit_error_flag,
    .single_bit_corrected_flag);
`default_nettype wire

// ==== sim/sacfg_host_model.sv ====
// host controller model: serial read-out of one register byte
`timescale 1ns/1ps
`default_nettype none
module sacfg_host_model (
    // link pins
    output logic     sck,
    output logic     cs_n,
    input wire logic so,
    input wire logic so_oe_n
);
    // a released output holds no valid level; show the inverse of the last bit
    wire so_line = so_oe_n ? ~so : so;
    // link clock stands still outside frames
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
    end
    // sample on rising edge, device shifts after falling edge; 64 ns period
    task automatic get_byte(output logic [7:0] b, output logic ok);
        cs_n = 1'b0;
        ok = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            #32 sck = 1'b1;
            b[i] = so_line;
            ok = ok && so_oe_n === 1'b0;
            #32 sck = 1'b0;
        end
        #32 cs_n = 1'b1;
    endtask : get_byte
endmodule : sacfg_host_model
`default_nettype wire

// ==== sim/sacfg_bank_tb.sv ====
// testbench: bank against a reference model
`timescale 1ns/1ps
`default_nettype none
module sacfg_bank_tb;
    logic clk_sys = 1'b0, srst = 1'b1, arch_reset_req = 1'b0, permanent_arch_lock = 1'b0;
    logic clear_ecc_status_cmd = 1'b0, wr_accept, wr_reject, option_locked, so, so_oe_n;
    logic sck, cs_n, dbl, sgl, m_lock, m_dbl, m_sgl, ok;
    logic [7:0] reg_rd_data, b;
    logic [3:0] active_option;
    logic [31:0] last_unit_addr, m_last;
    sacfg_pkg::sacfg_wr_s reg_wr = '0;
    sacfg_pkg::sacfg_rd_s array_rd = '0;
    sacfg_pkg::sacfg_sel_e reg_rd_sel = sacfg_pkg::SACFG_SEL_ARCH;
    int mismatches = 0, tests_run = 0, seed = 32'h4f69, m_opt, m_act;
    always #2 clk_sys = ~clk_sys;
    sacfg_bank #(.FACTORY_OPTION(4'h5)) i_dut (.clk_sys, .srst, .arch_reset_req,
        .permanent_arch_lock, .reg_wr, .reg_rd_sel, .reg_rd_data, .wr_accept, .wr_reject,
        .array_rd, .clear_ecc_status_cmd, .active_option, .option_locked, .last_unit_addr,
        .double_bit_error_flag(dbl), .single_bit_corrected_flag(sgl), .sck, .cs_n, .so,
        .so_oe_n);
    sacfg_host_model i_host (.sck, .cs_n, .so, .so_oe_n);
    // ------------------------------------------------------------
    // bus tasks and reference model
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset();
        srst = 1'b1;
        repeat (12) @(negedge clk_sys);
        srst = 1'b0;
        m_opt = 5;
        m_act = 5;
        {m_lock, m_dbl, m_sgl, m_last} = '0;
    endtask : do_reset
    // valid is left as given so back-to-back calls never assign it twice at one edge
    task automatic wr(input logic v, input logic e, input logic [7:0] d);
        logic take;
        take = v && !e && !m_lock && !permanent_arch_lock && d[3:0] <= 4'h7;
        reg_wr = '{v, sacfg_pkg::sacfg_sel_e'(e), d};
        @(negedge clk_sys);
        chk(wr_accept, take);
        chk(wr_reject, v && !take);
        if (take) m_opt = d[3:0];
        m_lock = m_lock | take;
    endtask : wr
    task automatic rd(input logic v, input logic [31:0] a, input logic s, d, c);
        array_rd = '{v, a, s, d};
        clear_ecc_status_cmd = c;
        @(negedge clk_sys);
        if (v) m_last = {a[31:4], 4'h0};
        m_dbl = (v && d) || (m_dbl && !c);
        m_sgl = (v && s) || (m_sgl && !c);
        chk(dbl, m_dbl);
        chk(sgl, m_sgl);
        chk(last_unit_addr, m_last);
        chk(sgl & ~dbl, m_sgl & ~m_dbl);
    endtask : rd
    task automatic regs();
        reg_rd_sel = sacfg_pkg::SACFG_SEL_ARCH;
        repeat (2) @(negedge clk_sys);
        chk(reg_rd_data, m_opt);
        reg_rd_sel = sacfg_pkg::SACFG_SEL_ECC;
        repeat (2) @(negedge clk_sys);
        chk(reg_rd_data, {m_dbl, m_sgl, 3'h0});
        chk(active_option, m_act);
        chk(option_locked, m_lock);
        #3 i_host.get_byte(b, ok);
        @(negedge clk_sys);
        repeat (6) @(negedge clk_sys);
        chk(b, {m_dbl, m_sgl, 3'h0});
        chk({ok, so_oe_n}, 2'h3);
    endtask : regs
    task automatic tally_and_finish();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        do_reset();
        regs();
        wr(1, 1, 8'hff);
        for (int o = 8; o < 16; o++) wr(1, 0, 8'(o));
        permanent_arch_lock = 1'b1;
        wr(1, 0, 8'h02);
        permanent_arch_lock = 1'b0;
        wr(0, 0, 8'h00);
        regs();
        // upper nibble written as zero, before any array read
        for (int o = 0; o < 8; o++) begin
            do_reset();
            wr(1, 0, 8'(o));
            wr(1, 0, 8'(7 - o));
            wr(0, 0, 8'h00);
            regs();
            arch_reset_req = 1'b1;
            @(negedge clk_sys);
            arch_reset_req = 1'b0;
            m_act = m_opt;
            regs();
        end
        for (int i = 0; i < 60; i++)
            rd(1'($random(seed)), $random(seed), 1'($random(seed)), 1'($random(seed)),
               ($random(seed) & 7) == 0);
        rd(1, 32'h0000_1234, 1, 1, 0);
        wr(1, 1, 8'h00);
        wr(0, 0, 8'h00);
        rd(1, 32'hffff_fffe, 0, 1, 1);
        rd(0, 0, 0, 0, 0);
        rd(0, 0, 0, 0, 1);
        regs();
        tally_and_finish();
    end
    initial begin
        #100us;
        mismatches++;
        tally_and_finish();
    end
endmodule : sacfg_bank_tb
`default_nettype wire
